// *** sdc_pkg.sv ***
package sdc_pkg;
	// timing figures in their own units; cycle counts derived at 40 MHz
	localparam int CLK_PERIOD_PS = 25000;
	localparam int TRP_NS = 20;
	localparam int MODE_LOAD_DELAY_NS = 15;
	localparam int REFRESH_CYCLE_TIME_NS = 72;
	localparam int TRAS_NS = 45;
	localparam int SELF_REFRESH_EXIT_DELAY_NS = 120;
	localparam int SELF_REFRESH_EXIT_DELAY_MIN_CYC = 2;
	localparam int REF_INTERVAL_NS = 15625;
	localparam int TRP_CYC = (TRP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MODE_LOAD_DELAY_CYC = (MODE_LOAD_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int REFRESH_CYCLE_TIME_CYC = (REFRESH_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TRAS_CYC = (TRAS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SELF_REFRESH_EXIT_DELAY_RAW = (SELF_REFRESH_EXIT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SELF_REFRESH_EXIT_DELAY_CYC = (SELF_REFRESH_EXIT_DELAY_RAW < SELF_REFRESH_EXIT_DELAY_MIN_CYC) ? SELF_REFRESH_EXIT_DELAY_MIN_CYC : SELF_REFRESH_EXIT_DELAY_RAW;
	localparam int REF_INTERVAL_CYC = (REF_INTERVAL_NS * 1000) / CLK_PERIOD_PS;
	localparam int TMR_W = 8;

	// command encodings as {ras_n, cas_n, we_n} with chip select low
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_RD = 3'h5;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_BT = 3'h6;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_LMR = 3'h0;

	localparam int AP_BIT = 10;
	localparam logic [1:0] BA_MR = 2'h0;
	localparam logic [1:0] BA_EMR = 2'h2;

	// mode and extended mode fields
	localparam int MR_IL_BIT = 3;
	localparam int MR_CL_LSB = 4;
	localparam int MR_WB_BIT = 9;
	localparam int EMR_DS_LSB = 5;
	localparam logic [2:0] CL_THREE = 3'h3;
	localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SELECT_ALL = 3'h0;
	localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SELECT_TWO = 3'h1;
	localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SELECT_ONE = 3'h2;
	localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SELECT_HALF = 3'h5;
	localparam logic [2:0] PARTIAL_ARRAY_REFRESH_SELECT_QUARTER = 3'h6;
	localparam logic [11:0] ROW_MASK_FULL = 12'hFFF;
	localparam logic [11:0] ROW_MASK_HALF = 12'h7FF;
	localparam logic [11:0] ROW_MASK_QUARTER = 12'h3FF;
	localparam logic [11:0] MR_RST = 12'h020;
	localparam logic [11:0] EMR_RST = 12'h000;

	// register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MODE = 8'h08;
	localparam logic [7:0] REG_REFRESH = 8'h0C;
	localparam logic [3:0] REG_ROW_PAGE = 4'h1;
	localparam int ST_BUSY_LSB = 4;
	localparam int ST_PWR_LSB = 8;
	localparam int ST_BURST_BIT = 10;
	localparam int ST_VIOL_LSB = 16;
	localparam int ST_LOST_LSB = 20;
	localparam int ST_PART_BIT = 24;
	localparam int MODE_EMR_LSB = 16;
	localparam logic [15:0] CTRL_RST = 16'(REF_INTERVAL_CYC);

	typedef enum logic [1:0] {PWR_NORMAL, PWR_SELF_REFRESH, PWR_DEEP_DOWN} sdc_pwr_t;
endpackage

// *** sdc_device.sv ***
// Notes on behaviour
// - chip select high ignores inputs; select with all-high lines is a no-op
// - activate: ras low, bank picks one of four, twelve address lines pick row
// - read/write: cas low, we picks direction, nine-bit column, bit 10 auto precharge
// - opened row stays open until its bank is precharged
// - read mask high floats that lane two clocks later, low drives data
// - write mask high blocks that byte in the same cycle
// - lower mask governs bits 0-7, upper mask bits 8-15
// - we-only-low code is burst terminate with cke high, deep power-down with cke low
// - burst terminate truncates the latest read or write burst
// - precharge closes named bank, or all banks when bit 10 high
// - precharged bank idle only after precharge time; needs fresh activation
// - auto precharge closes the row at burst end for that access only
// - refresh code: auto refresh with cke high, self refresh with cke low
// - mode loads need all banks idle, then a mode-load delay
// - in self refresh only cke matters; stay at least row-active time
// - self refresh covers only the partial-array region
// - deep power-down entered when idle, left on cke high, data lost
// - two extended bits choose full, half or quarter drive strength
// - mode load with bank 1 high, bank 0 low targets extended register
// - partial array: all, banks 0-1, bank 0, half or quarter of bank 0
`timescale 1ns/1ps
module sdc_device
	import sdc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [1:0] ba_i,
	input wire logic [11:0] addr_i,
	input wire logic lower_byte_mask_i,
	input wire logic upper_byte_mask_i,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o,
	output logic [1:0] dq_oe_o,
	output logic [1:0] drive_strength_o,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o
);
	sdc_pwr_t pwr;
	logic [2:0] cmd;
	logic live, live_lowcke;
	logic cmd_act, cmd_rd, cmd_wr, cmd_bt, cmd_pre, cmd_ref, cmd_lmr, cmd_sr, cmd_dpd;
	logic [3:0] bank_active, bank_busy;
	logic [11:0] open_row [4];
	logic all_idle, ref_ok, lmr_ok, sr_exit;
	logic [11:0] mr, emr, ref_row, row_mask, sel_row;
	logic [TMR_W-1:0] busy_cnt, sr_cnt;
	logic [15:0] sr_period, osc_cnt;
	logic [1:0] viol;
	logic [3:0] lost;
	logic part_lost;
	logic burst_active, burst_read, burst_ap;
	logic [1:0] burst_bank;
	logic [8:0] burst_start;
	logic [2:0] burst_k;
	logic [3:0] burst_left, bl_len, start_len;
	logic start_rw, cont, proc_valid, proc_read, done_ap, cl3;
	logic [1:0] proc_bank, done_bank, dqm_in, dqm_q;
	logic [8:0] proc_col;
	logic [15:0] lane_rd, rd_d0, rd_d1;
	logic rd_v0, rd_v1;
	logic addr_ok, wr_pend, st_clr;
	logic [7:0] wr_addr;
	logic [31:0] rd_mux;

	function automatic logic [8:0] col_at(input logic [8:0] s, input logic [2:0] k, input logic [2:0] m,
		input logic il);
		logic [2:0] off;
		off = il ? (s[2:0] ^ k) : (s[2:0] + k);
		return {s[8:3], (s[2:0] & ~m) | (off & m)};
	endfunction

	// command decode
	assign cmd = {ras_n_i, cas_n_i, we_n_i};
	assign live = (pwr == PWR_NORMAL) && cke_i && !cs_n_i;
	assign live_lowcke = (pwr == PWR_NORMAL) && !cke_i && !cs_n_i;
	assign cmd_act = live && (cmd == CMD_ACT);
	assign cmd_rd = live && (cmd == CMD_RD);
	assign cmd_wr = live && (cmd == CMD_WR);
	assign cmd_bt = live && (cmd == CMD_BT);
	assign cmd_pre = live && (cmd == CMD_PRE);
	assign cmd_ref = live && (cmd == CMD_REF);
	assign cmd_lmr = live && (cmd == CMD_LMR);
	assign all_idle = (bank_active == 4'h0) && (bank_busy == 4'h0);
	assign cmd_sr = live_lowcke && (cmd == CMD_REF);
	assign cmd_dpd = live_lowcke && (cmd == CMD_BT) && all_idle;
	assign ref_ok = cmd_ref && all_idle;
	assign lmr_ok = cmd_lmr && all_idle;
	assign sr_exit = (pwr == PWR_SELF_REFRESH) && cke_i;
	assign sel_row = open_row[ba_i];
	assign dqm_in = {upper_byte_mask_i, lower_byte_mask_i};
	assign cl3 = (mr[MR_CL_LSB+:3] == CL_THREE);

	// burst sequencing
	always_comb begin
		case (mr[2:0])
			3'h1: bl_len = 4'h2;
			3'h2: bl_len = 4'h4;
			3'h3: bl_len = 4'h8;
			default: bl_len = 4'h1;
		endcase
	end
	assign start_rw = (cmd_rd || cmd_wr) && bank_active[ba_i];
	assign start_len = (cmd_wr && mr[MR_WB_BIT]) ? 4'h1 : bl_len;
	assign cont = burst_active && cke_i && !start_rw && !cmd_bt
		&& !(cmd_pre && (addr_i[AP_BIT] || ba_i == burst_bank));
	assign proc_valid = start_rw || cont;
	assign proc_read = start_rw ? cmd_rd : burst_read;
	assign proc_bank = start_rw ? ba_i : burst_bank;
	assign proc_col = start_rw ? addr_i[8:0]
		: col_at(burst_start, burst_k, 3'(bl_len - 4'h1), mr[MR_IL_BIT]);
	assign done_ap = (start_rw && start_len == 4'h1 && addr_i[AP_BIT])
		|| (cont && burst_left == 4'h1 && burst_ap);
	assign done_bank = start_rw ? ba_i : burst_bank;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			burst_active <= 1'b0;
			burst_read <= 1'b0;
			burst_bank <= 2'h0;
			burst_start <= 9'h000;
			burst_k <= 3'h0;
			burst_left <= 4'h0;
			burst_ap <= 1'b0;
		end else if (start_rw) begin
			burst_active <= (start_len != 4'h1);
			burst_read <= cmd_rd;
			burst_bank <= ba_i;
			burst_start <= addr_i[8:0];
			burst_k <= 3'h1;
			burst_left <= start_len - 4'h1;
			burst_ap <= addr_i[AP_BIT];
		end else if (cont) begin
			burst_k <= burst_k + 3'h1;
			burst_left <= burst_left - 4'h1;
			if (burst_left == 4'h1) begin
				burst_active <= 1'b0;
			end
		end else if (burst_active && cke_i) begin
			burst_active <= 1'b0;
		end
	end

	// byte lanes: array storage, write mask with no latency
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_lane
			logic [7:0] lane_mem [64];
			always_ff @(posedge clk_sys_i) begin
				if (proc_valid && !proc_read && !dqm_in[g]) begin
					lane_mem[{proc_bank, proc_col[3:0]}] <= dq_i[g*8+:8];
				end
			end
			assign lane_rd[g*8+:8] = lane_mem[{proc_bank, proc_col[3:0]}];
		end
	endgenerate

	// read pipeline, cas latency two or three, mask latency two
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_v0 <= 1'b0;
			rd_v1 <= 1'b0;
			rd_d0 <= 16'h0000;
			rd_d1 <= 16'h0000;
			dqm_q <= 2'h3;
			dq_o <= 16'h0000;
			dq_oe_o <= 2'h0;
		end else begin
			rd_v0 <= proc_valid && proc_read;
			rd_d0 <= lane_rd;
			rd_v1 <= rd_v0;
			rd_d1 <= rd_d0;
			dqm_q <= dqm_in;
			dq_o <= cl3 ? rd_d1 : rd_d0;
			dq_oe_o <= {2{cl3 ? rd_v1 : rd_v0}} & ~dqm_q;
		end
	end

	// per-bank state and open row
	generate
		for (g = 0; g < 4; g++) begin : gen_bank
			logic [TMR_W-1:0] trp;
			always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					bank_active[g] <= 1'b0;
					open_row[g] <= 12'h000;
					trp <= '0;
				end else if (cmd_act && ba_i == 2'(g) && !bank_active[g]) begin
					bank_active[g] <= 1'b1;
					open_row[g] <= addr_i;
					trp <= '0;
				end else if ((cmd_pre && (addr_i[AP_BIT] || ba_i == 2'(g)))
					|| (done_ap && done_bank == 2'(g))) begin
					bank_active[g] <= 1'b0;
					trp <= TMR_W'(TRP_CYC);
				end else if (trp != '0) begin
					trp <= trp - 1'b1;
				end
			end
			assign bank_busy[g] = (trp != '0);
		end
	endgenerate

	// mode and extended mode registers
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mr <= MR_RST;
			emr <= EMR_RST;
			drive_strength_o <= EMR_RST[EMR_DS_LSB+:2];
		end else if (lmr_ok && ba_i == BA_MR) begin
			mr <= addr_i;
		end else if (lmr_ok && ba_i == BA_EMR) begin
			emr <= addr_i;
			drive_strength_o <= addr_i[EMR_DS_LSB+:2];
		end
	end

	// power states
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pwr <= PWR_NORMAL;
			sr_cnt <= '0;
		end else begin
			case (pwr)
				PWR_NORMAL: begin
					if (cmd_sr) begin
						pwr <= PWR_SELF_REFRESH;
						sr_cnt <= TMR_W'(TRAS_CYC);
					end else if (cmd_dpd) begin
						pwr <= PWR_DEEP_DOWN;
					end
				end
				PWR_SELF_REFRESH: begin
					if (cke_i) begin
						pwr <= PWR_NORMAL;
					end else if (sr_cnt != '0) begin
						sr_cnt <= sr_cnt - 1'b1;
					end
				end
				PWR_DEEP_DOWN: begin
					if (cke_i) begin
						pwr <= PWR_NORMAL;
					end
				end
				default: pwr <= PWR_NORMAL;
			endcase
		end
	end

	// global wait after mode load, refresh and self refresh exit
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_cnt <= '0;
		end else if (sr_exit) begin
			busy_cnt <= TMR_W'(SELF_REFRESH_EXIT_DELAY_CYC);
		end else if (lmr_ok) begin
			busy_cnt <= TMR_W'(MODE_LOAD_DELAY_CYC);
		end else if (ref_ok) begin
			busy_cnt <= TMR_W'(REFRESH_CYCLE_TIME_CYC);
		end else if (busy_cnt != '0) begin
			busy_cnt <= busy_cnt - 1'b1;
		end
	end

	// refresh row counter shared by auto and self refresh
	always_comb begin
		case (emr[2:0])
			PARTIAL_ARRAY_REFRESH_SELECT_HALF: row_mask = ROW_MASK_HALF;
			PARTIAL_ARRAY_REFRESH_SELECT_QUARTER: row_mask = ROW_MASK_QUARTER;
			default: row_mask = ROW_MASK_FULL;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ref_row <= 12'h000;
			osc_cnt <= CTRL_RST;
		end else if (ref_ok) begin
			ref_row <= ref_row + 12'h001;
		end else if (cmd_sr) begin
			osc_cnt <= sr_period;
		end else if (pwr == PWR_SELF_REFRESH && !cke_i) begin
			if (osc_cnt == 16'h0000) begin
				osc_cnt <= sr_period;
				ref_row <= (ref_row + 12'h001) & row_mask;
			end else begin
				osc_cnt <= osc_cnt - 16'h0001;
			end
		end
	end

	// data loss outside the refreshed region, sticky until cleared
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lost <= 4'h0;
			part_lost <= 1'b0;
		end else begin
			if (cmd_dpd) begin
				lost <= 4'hF;
			end else if (cmd_sr) begin
				case (emr[2:0])
					PARTIAL_ARRAY_REFRESH_SELECT_ALL: lost <= lost & ~({4{st_clr}} & hwdata_i[ST_LOST_LSB+:4]);
					PARTIAL_ARRAY_REFRESH_SELECT_TWO: lost <= lost | 4'hC;
					PARTIAL_ARRAY_REFRESH_SELECT_ONE, PARTIAL_ARRAY_REFRESH_SELECT_HALF, PARTIAL_ARRAY_REFRESH_SELECT_QUARTER: lost <= lost | 4'hE;
					default: lost <= lost;
				endcase
			end else if (st_clr) begin
				lost <= lost & ~hwdata_i[ST_LOST_LSB+:4];
			end
			if (cmd_sr && (emr[2:0] == PARTIAL_ARRAY_REFRESH_SELECT_HALF || emr[2:0] == PARTIAL_ARRAY_REFRESH_SELECT_QUARTER)) begin
				part_lost <= 1'b1;
			end else if (cmd_dpd) begin
				part_lost <= 1'b1;
			end else if (st_clr && hwdata_i[ST_PART_BIT]) begin
				part_lost <= 1'b0;
			end
		end
	end

	// sticky protocol and timing faults, set wins over clear
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			viol <= 2'h0;
		end else begin
			viol <= (viol & ~({2{st_clr}} & hwdata_i[ST_VIOL_LSB+:2]))
				| {(cmd_act && bank_active[ba_i]) || ((cmd_rd || cmd_wr) && !bank_active[ba_i])
					|| ((cmd_ref || cmd_lmr) && !all_idle) || (live_lowcke && cmd == CMD_BT && !all_idle),
					(live && cmd != CMD_NOP && busy_cnt != '0) || (cmd_act && bank_busy[ba_i])
					|| (sr_exit && sr_cnt != '0)};
		end
	end

	// ahb-lite slave, zero wait states
	assign addr_ok = hsel_i && htrans_i[1] && hready_i;
	assign st_clr = wr_pend && (wr_addr == REG_STATUS);

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (haddr_i[31:8] == 24'h000000) begin
			case (haddr_i[7:0])
				REG_CTRL: rd_mux = {16'h0000, sr_period};
				REG_STATUS: rd_mux = {7'h00, part_lost, lost, 2'h0, viol, 5'h00, burst_active, pwr,
					bank_busy, bank_active};
				REG_MODE: rd_mux = {4'h0, emr, 4'h0, mr};
				REG_REFRESH: rd_mux = {20'h00000, ref_row};
				default: begin
					if (haddr_i[7:4] == REG_ROW_PAGE && haddr_i[1:0] == 2'h0) begin
						rd_mux = {20'h00000, open_row[haddr_i[3:2]]};
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata_o <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			wr_pend <= addr_ok && hwrite_i;
			wr_addr <= (haddr_i[31:8] == 24'h000000) ? haddr_i[7:0] : 8'hFF;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			if (addr_ok && !hwrite_i) begin
				hrdata_o <= rd_mux;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sr_period <= CTRL_RST;
		end else if (wr_pend && wr_addr == REG_CTRL) begin
			sr_period <= hwdata_i[15:0];
		end
	end

	// checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);

	a_inhibit_hold: assert property (cs_n_i && !burst_active |=> $stable(bank_active))
		else $error("bank state changed while deselected");
	a_act_opens: assert property (cmd_act && !bank_active[ba_i] |=> bank_active[$past(ba_i)]
		&& open_row[$past(ba_i)] == $past(addr_i))
		else $error("activate did not open row");
	a_row_kept: assert property (cmd_act && bank_active[ba_i] |=> open_row[$past(ba_i)] == $past(sel_row))
		else $error("open row replaced without precharge");
	a_rd_mask_lo: assert property (lower_byte_mask_i |-> ##2 !dq_oe_o[0])
		else $error("masked lower lane driven");
	a_rd_mask_hi: assert property (upper_byte_mask_i |-> ##2 !dq_oe_o[1])
		else $error("masked upper lane driven");
	a_rd_data_on: assert property (start_rw && cmd_rd && !cl3 && !lower_byte_mask_i |-> ##2 dq_oe_o[0])
		else $error("read data not driven at latency two");
	a_bt_stops: assert property (cmd_bt |=> !burst_active)
		else $error("burst continued after terminate");
	a_pre_all: assert property (cmd_pre && addr_i[AP_BIT] |=> bank_active == 4'h0 && bank_busy == 4'hF)
		else $error("precharge all incomplete");
	a_ap_close: assert property (done_ap |=> !bank_active[$past(done_bank)])
		else $error("auto precharge left row open");
	a_ref_row: assert property (ref_ok |=> ref_row == $past(ref_row) + 12'h001)
		else $error("refresh counter did not advance");
	a_sr_hold: assert property (pwr == PWR_SELF_REFRESH && !cke_i |=> pwr == PWR_SELF_REFRESH)
		else $error("self refresh left with cke low");
	a_dpd_enter: assert property (cmd_dpd |=> pwr == PWR_DEEP_DOWN && lost == 4'hF)
		else $error("deep power-down not entered");
	a_emr_load: assert property (lmr_ok && ba_i == BA_EMR |=> emr == $past(addr_i)
		&& drive_strength_o == $past(addr_i[EMR_DS_LSB+:2]))
		else $error("extended load or drive strength wrong");
	a_partial_array_refresh_select_half: assert property (pwr == PWR_SELF_REFRESH && !cke_i && osc_cnt == 16'h0000
		&& emr[2:0] == PARTIAL_ARRAY_REFRESH_SELECT_HALF |=> !ref_row[11])
		else $error("refresh outside half-bank region");

	c_read: cover property (start_rw && cmd_rd);
	c_bt_cut: cover property (cmd_bt && burst_active);
	c_self_ref: cover property (cmd_sr ##[1:20] sr_exit);
	c_deep: cover property (cmd_dpd);
endmodule // sdc_device

// *** sdc_ctl_model.sv ***
`timescale 1ns/1ps
module sdc_ctl_model
	import sdc_pkg::*;
(
	input wire logic clk_i,
	output logic cke_o,
	output logic cs_n_o,
	output logic [2:0] cmd_o,
	output logic [1:0] ba_o,
	output logic [11:0] addr_o,
	output logic [1:0] mask_o,
	output logic [15:0] dq_o
);
	initial begin
		cke_o = 1'b1;
		cs_n_o = 1'b1;
		cmd_o = CMD_NOP;
		ba_o = 2'h0;
		addr_o = 12'h000;
		mask_o = 2'h0;
		dq_o = 16'h0000;
	end

	// one command for one cycle, then a selected nop with the data lines turned over
	task automatic issue(input logic s_n, input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic [1:0] m, input logic [15:0] d, input logic k);
		@(posedge clk_i);
		cs_n_o <= s_n;
		cmd_o <= c;
		ba_o <= b;
		addr_o <= a;
		mask_o <= m;
		dq_o <= d;
		cke_o <= k;
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		cmd_o <= CMD_NOP;
		mask_o <= 2'h0;
		dq_o <= ~d;
		addr_o <= ~a;
	endtask
endmodule // sdc_ctl_model

// *** tb_sdc_device.sv ***
`timescale 1ns/1ps
module tb_sdc_device
	import sdc_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic cke, cs_n, hreadyout_o, hresp_o;
	logic [2:0] cmd;
	logic [1:0] ba, mask, dq_oe_o, drive_strength_o;
	logic [11:0] addr;
	logic [15:0] dq_w, dq_o;
	logic [31:0] hrdata_o, rd;
	logic hsel_i = 1'b0;
	logic hwrite_i = 1'b0;
	logic [1:0] htrans_i = 2'h0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;

	always #12.5 clk_sys_i = ~clk_sys_i;

	sdc_ctl_model sdc_ctl_model_inst (.clk_i(clk_sys_i), .cke_o(cke), .cs_n_o(cs_n), .cmd_o(cmd), .ba_o(ba),
		.addr_o(addr), .mask_o(mask), .dq_o(dq_w));

	sdc_device sdc_device_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .cke_i(cke), .cs_n_i(cs_n),
		.ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .ba_i(ba), .addr_i(addr),
		.lower_byte_mask_i(mask[0]), .upper_byte_mask_i(mask[1]), .dq_i(dq_w), .dq_o(dq_o),
		.dq_oe_o(dq_oe_o), .drive_strength_o(drive_strength_o), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));

	task automatic conclude();
		if (n_fail == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
		@(posedge clk_sys_i);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= a;
		hwrite_i <= w;
		do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
		d = hrdata_o;
		hsel_i <= 1'b0;
	endtask

	task automatic reg_chk(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0, d);
		check(d & m, exp);
	endtask

	task automatic go(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a, input logic [1:0] m,
		input logic [15:0] d, input logic k);
		sdc_ctl_model_inst.issue(1'b0, c, b, a, m, d, k);
	endtask

	// read, masks at the command edge (they govern latency two); looked at while the first element stands
	task automatic rd_chk(input logic [1:0] b, input logic [11:0] col, input logic [1:0] m,
		input logic [1:0] oe, input logic [15:0] d, input int lat);
		go(CMD_RD, b, col, m, 16'h0, 1'b1);
		repeat (lat - 1) @(posedge clk_sys_i);
		#1;
		check({30'h0, dq_oe_o}, {30'h0, oe});
		check({16'h0, dq_o & {{8{oe[1]}}, {8{oe[0]}}}}, {16'h0, d});
	endtask

	initial begin
		repeat (16) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		#1;
		check({28'h0, dq_oe_o, drive_strength_o}, 32'h0);
		check({30'h0, hresp_o, hreadyout_o}, 32'h1);
		for (int i = 0; i < 3; i++) begin
			go(CMD_LMR, BA_EMR, 12'(i << EMR_DS_LSB) | 12'(PARTIAL_ARRAY_REFRESH_SELECT_HALF), 2'h0, 16'h0, 1'b1);
			repeat (MODE_LOAD_DELAY_CYC) @(posedge clk_sys_i);
			#1;
			check({30'h0, drive_strength_o}, 32'(i));
		end
		reg_chk(REG_MODE, 32'h0045_0020, 32'h0FFF_0FFF);
		reg_chk(32'h0000_0040, 32'h0, 32'hFFFF_FFFF);
		sdc_ctl_model_inst.issue(1'b1, CMD_ACT, 2'h2, 12'h123, 2'h0, 16'h0, 1'b1);
		go(CMD_ACT, 2'h1, 12'hABC, 2'h0, 16'h0, 1'b1);
		go(CMD_ACT, 2'h1, 12'h555, 2'h0, 16'h0, 1'b1);
		reg_chk(REG_STATUS, 32'h0002_0002, 32'h0002_000F);
		reg_chk(32'h0000_0014, 32'h0000_0ABC, 32'h0000_0FFF);
		ahb(1'b1, REG_STATUS, 32'h01F3_0000, rd);
		go(CMD_WR, 2'h1, 12'h003, 2'h0, 16'hAAAA, 1'b1);
		go(CMD_WR, 2'h1, 12'h003, 2'h1, 16'h5555, 1'b1);
		repeat (2) @(posedge clk_sys_i);
		rd_chk(2'h1, 12'h003, 2'h0, 2'h3, 16'h55AA, 2);
		repeat (2) @(posedge clk_sys_i);
		rd_chk(2'h1, 12'h003, 2'h2, 2'h1, 16'h00AA, 2);
		repeat (2) @(posedge clk_sys_i);
		go(CMD_PRE, 2'h1, 12'h000, 2'h0, 16'h0, 1'b1);
		repeat (TRP_CYC + 1) @(posedge clk_sys_i);
		go(CMD_RD, 2'h1, 12'h003, 2'h0, 16'h0, 1'b1);
		repeat (1) @(posedge clk_sys_i);
		#1;
		check({30'h0, dq_oe_o}, 32'h0);
		reg_chk(REG_STATUS, 32'h0002_0000, 32'h0002_00FF);
		go(CMD_ACT, 2'h0, 12'h001, 2'h0, 16'h0, 1'b1);
		go(CMD_ACT, 2'h3, 12'h002, 2'h0, 16'h0, 1'b1);
		go(CMD_WR, 2'h0, 12'h400, 2'h0, 16'h1234, 1'b1);
		repeat (TRP_CYC + 2) @(posedge clk_sys_i);
		reg_chk(REG_STATUS, 32'h0000_0008, 32'h0000_00FF);
		go(CMD_PRE, 2'h0, 12'h400, 2'h0, 16'h0, 1'b1);
		repeat (TRP_CYC + 1) @(posedge clk_sys_i);
		reg_chk(REG_STATUS, 32'h0, 32'h0000_00FF);
		go(CMD_REF, 2'h0, 12'hFFF, 2'h0, 16'h0, 1'b1);
		repeat (REFRESH_CYCLE_TIME_CYC) @(posedge clk_sys_i);
		reg_chk(REG_REFRESH, 32'h1, 32'h0000_0FFF);
		ahb(1'b1, REG_CTRL, 32'h0000_0002, rd);
		reg_chk(REG_CTRL, 32'h0000_0002, 32'h0000_FFFF);
		go(CMD_REF, 2'h0, 12'h000, 2'h0, 16'h0, 1'b0);
		go(CMD_ACT, 2'h0, 12'h001, 2'h0, 16'h0, 1'b0);
		repeat (TRAS_CYC) @(posedge clk_sys_i);
		reg_chk(REG_STATUS, 32'h0000_0100, 32'h0000_030F);
		go(CMD_NOP, 2'h0, 12'h000, 2'h0, 16'h0, 1'b1);
		repeat (SELF_REFRESH_EXIT_DELAY_CYC) @(posedge clk_sys_i);
		go(CMD_REF, 2'h0, 12'h000, 2'h0, 16'h0, 1'b1);
		repeat (REFRESH_CYCLE_TIME_CYC) @(posedge clk_sys_i);
		reg_chk(REG_STATUS, 32'h01E0_0000, 32'h01F0_030F);
		go(CMD_LMR, BA_MR, 12'h022, 2'h0, 16'h0, 1'b1);
		repeat (MODE_LOAD_DELAY_CYC) @(posedge clk_sys_i);
		go(CMD_ACT, 2'h2, 12'h007, 2'h0, 16'h0, 1'b1);
		go(CMD_RD, 2'h2, 12'h000, 2'h0, 16'h0, 1'b1);
		go(CMD_BT, 2'h0, 12'h000, 2'h0, 16'h0, 1'b1);
		repeat (2) @(posedge clk_sys_i);
		#1;
		check({30'h0, dq_oe_o}, 32'h0);
		go(CMD_PRE, 2'h0, 12'h400, 2'h0, 16'h0, 1'b1);
		repeat (TRP_CYC + 1) @(posedge clk_sys_i);
		go(CMD_LMR, BA_MR, 12'h030, 2'h0, 16'h0, 1'b1);
		repeat (MODE_LOAD_DELAY_CYC) @(posedge clk_sys_i);
		go(CMD_ACT, 2'h1, 12'h000, 2'h0, 16'h0, 1'b1);
		rd_chk(2'h1, 12'h003, 2'h0, 2'h3, 16'h55AA, 3);
		go(CMD_PRE, 2'h0, 12'h400, 2'h0, 16'h0, 1'b1);
		repeat (TRP_CYC + 1) @(posedge clk_sys_i);
		go(CMD_BT, 2'h0, 12'h000, 2'h0, 16'h0, 1'b0);
		reg_chk(REG_STATUS, 32'h0000_0200, 32'h0000_0300);
		go(CMD_NOP, 2'h0, 12'h000, 2'h0, 16'h0, 1'b1);
		repeat (2) @(posedge clk_sys_i);
		reg_chk(REG_STATUS, 32'h00F0_0000, 32'h00F0_0300);
		conclude();
	end
endmodule // tb_sdc_device
